// >>> hsm_core.sv
// Purpose: Host shared-memory control core of a 10/100 MAC
// Assumes: Host accesses arrive on the core clock as word accesses
// Notes: Action and receive datapaths sit outside this core
// Contract
// (RULE_01) Region on chip, I/O and memory access
// (RULE_02) First eight bytes form system control block
// (RULE_03) Engines change state only by host codes; code also moves them on list end, suspend bit and no-space events
// (RULE_04) Engine status posted, changes raise interrupt; changes made by software reset raise none
// (RULE_05) Control block pointers locate both lists
// (RULE_06) Command blocks: non-transmit or transmit kinds
// (RULE_07) Receive data follows its descriptor directly
// (RULE_08) EEPROM and PHY control at 0Ch-14h
// (RULE_09) No traffic after reset until configure
// (RULE_10) Hardware reset clears everything incl. PCI
// (RULE_11) Software reset keeps only PCI configuration
// (RULE_12) Selective reset keeps setup, idles engines
// (RULE_13) Self test: selective, test, software reset
// (RULE_14) Control block write triggers full fetch
// (RULE_15) Commands ignored while reset in progress
`timescale 1ns/1ps
module hsm_core (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic acc_valid_in,
   input wire logic acc_write_in,
   input wire logic acc_io_space_in,
   input wire logic [4:0] acc_offset_in,
   input wire logic [31:0] acc_wdata_in,
   output logic [31:0] acc_rdata_out,
   input wire logic pci_cfg_wr_in,
   input wire logic [31:0] pci_cfg_data_in,
   output logic [31:0] pci_cfg_out,
   input wire logic cu_list_end_in,
   input wire logic cu_suspend_bit_in,
   input wire logic [2:0] action_code_in,
   input wire logic action_done_in,
   input wire logic frame_rx_in,
   input wire logic ru_no_space_in,
   input wire logic [31:0] rfd_addr_in,
   input wire logic err_event_in,
   input wire logic setup_wr_in,
   input wire logic [3:0] setup_addr_in,
   input wire logic [31:0] setup_data_in,
   input wire logic eeprom_data_pin_in,
   output logic scb_fetch_out,
   output logic [31:0] cu_list_ptr_out,
   output logic [31:0] ru_area_ptr_out,
   output logic [31:0] rfd_data_addr_out,
   output logic action_is_tx_out,
   output logic tx_enable_out,
   output logic rx_enable_out,
   output logic irq_out,
   output logic [31:0] eeprom_ctrl_out,
   output logic [31:0] phy_mgmt_ctrl_out,
   output logic [31:0] setup_rd_data_out,
   output logic selftest_busy_out
);
   ////////////////////////////////////////////////////////////////////
   logic rst_meta, rst_n;
   logic ee_meta, ee_sync;
   hsm_pkg::hsm_eng_t cu_reg, cu_next, ru_reg, ru_next;
   hsm_pkg::hsm_rst_t rs_reg, rs_next;
   logic [15:0] cmd_reg;
   logic [31:0] gp_reg, cu_base_reg, ru_base_reg, hds_reg, err_cnt_reg;
   logic [3:0] ack_reg;
   logic fetch_reg, cfg_done_reg, setup_ok_reg, st_reg;
   logic [5:0] st_cnt_reg;

   function automatic logic hit(input logic [4:0] ofs, input logic [4:0] want);
      hit = (ofs[4:2] == want[4:2]);
   endfunction

   // Reset release through two flops, assertion stays asynchronous
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         ee_meta <= 1'b0;
         ee_sync <= 1'b0;
      end else begin
         ee_meta <= eeprom_data_pin_in;
         ee_sync <= ee_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Address space is ignored: I/O and memory decode alike
   wire wr = acc_valid_in && acc_write_in; // see (RULE_01)
   wire rd = acc_valid_in && !acc_write_in;
   wire wr_scb = wr && (hit(acc_offset_in, hsm_pkg::OFS_SCB_WORD) ||
      hit(acc_offset_in, hsm_pkg::OFS_GEN_PTR)); // see (RULE_02)
   wire wr_port = wr && hit(acc_offset_in, hsm_pkg::OFS_PORT);
   wire [3:0] port_op = acc_wdata_in[3:0];
   wire sel_clr = (rs_reg == hsm_pkg::RS_SEL);
   wire soft_clr = (rs_reg == hsm_pkg::RS_SOFT);
   wire busy = (rs_reg != hsm_pkg::RS_NONE);
   wire cmd_ok = fetch_reg && !busy; // see (RULE_15)
   wire [3:0] cu_cmd = cmd_reg[hsm_pkg::CU_CMD_LSB-16 +: 4];
   wire [2:0] ru_cmd = cmd_reg[hsm_pkg::RU_CMD_LSB-16 +: 3];
   wire both_idle = (cu_reg == hsm_pkg::ENG_IDLE) &&
      (ru_reg == hsm_pkg::ENG_IDLE);
   wire [3:0] ack_set = {ru_next != ru_reg, cu_next != cu_reg,
      frame_rx_in, action_done_in};
   wire [3:0] ack_clr = (wr && hit(acc_offset_in, hsm_pkg::OFS_SCB_WORD)) ?
      acc_wdata_in[hsm_pkg::ACK_LSB +: 4] : 4'h0;

   // Engines move only on host codes, resets or their own list events
   always_comb begin
      cu_next = cu_reg;
      if (sel_clr || soft_clr) begin
         cu_next = hsm_pkg::ENG_IDLE;
      end else if (cmd_ok && cu_cmd == hsm_pkg::CU_START) begin
         cu_next = hsm_pkg::ENG_ACTIVE; // see (RULE_03)
      end else if (cmd_ok && cu_cmd == hsm_pkg::CU_RESUME &&
         cu_reg == hsm_pkg::ENG_SUSP) begin
         cu_next = hsm_pkg::ENG_ACTIVE;
      end else if (cmd_ok && cu_cmd == hsm_pkg::CU_ABORT) begin
         cu_next = hsm_pkg::ENG_IDLE;
      end else if (cu_reg == hsm_pkg::ENG_ACTIVE && cu_list_end_in) begin
         cu_next = hsm_pkg::ENG_IDLE;
      end else if (cu_reg == hsm_pkg::ENG_ACTIVE && cu_suspend_bit_in) begin
         cu_next = hsm_pkg::ENG_SUSP;
      end
   end

   always_comb begin
      ru_next = ru_reg;
      if (sel_clr || soft_clr) begin
         ru_next = hsm_pkg::ENG_IDLE; // see (RULE_12)
      end else if (cmd_ok && ru_cmd == hsm_pkg::RU_START) begin
         ru_next = hsm_pkg::ENG_ACTIVE; // see (RULE_03)
      end else if (cmd_ok && ru_cmd == hsm_pkg::RU_RESUME &&
         ru_reg == hsm_pkg::ENG_SUSP) begin
         ru_next = hsm_pkg::ENG_ACTIVE;
      end else if (cmd_ok && ru_cmd == hsm_pkg::RU_ABORT) begin
         ru_next = hsm_pkg::ENG_IDLE;
      end else if (ru_reg == hsm_pkg::ENG_ACTIVE && ru_no_space_in) begin
         ru_next = hsm_pkg::ENG_SUSP;
      end
   end

   // Reset sequencer; self test wraps its run in two resets
   always_comb begin
      rs_next = rs_reg;
      case (rs_reg)
         hsm_pkg::RS_NONE: begin
            if (wr_port && port_op == hsm_pkg::PORT_SW_RESET) begin
               rs_next = hsm_pkg::RS_SOFT; // see (RULE_11)
            end else if (wr_port && (port_op == hsm_pkg::PORT_SEL_RESET ||
               port_op == hsm_pkg::PORT_SELFTEST)) begin
               rs_next = hsm_pkg::RS_SEL; // see (RULE_13)
            end
         end
         hsm_pkg::RS_SEL: rs_next = st_reg ? hsm_pkg::RS_TEST :
            hsm_pkg::RS_NONE;
         hsm_pkg::RS_TEST: begin
            if (st_cnt_reg == 6'(hsm_pkg::SELFTEST_CYC - 1)) begin
               rs_next = hsm_pkg::RS_SOFT; // see (RULE_13)
            end
         end
         hsm_pkg::RS_SOFT: rs_next = hsm_pkg::RS_NONE;
         default: rs_next = hsm_pkg::RS_NONE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Hardware reset clears every register here, PCI copy included
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin // see (RULE_10)
         cu_reg <= hsm_pkg::ENG_IDLE;
         ru_reg <= hsm_pkg::ENG_IDLE;
         rs_reg <= hsm_pkg::RS_NONE;
         pci_cfg_out <= 32'h0000_0000;
         st_reg <= 1'b0;
         st_cnt_reg <= 6'h00;
         fetch_reg <= 1'b0;
         ack_reg <= 4'h0;
      end else begin
         cu_reg <= cu_next;
         ru_reg <= ru_next;
         rs_reg <= rs_next;
         if (pci_cfg_wr_in) begin
            pci_cfg_out <= pci_cfg_data_in;
         end
         if (rs_reg == hsm_pkg::RS_NONE) begin
            st_reg <= wr_port && port_op == hsm_pkg::PORT_SELFTEST;
         end
         st_cnt_reg <= (rs_reg == hsm_pkg::RS_TEST) ? st_cnt_reg + 6'h01 :
            6'h00;
         fetch_reg <= wr_scb; // see (RULE_14)
         // Set beats clear so no status change is lost outside software reset
         ack_reg <= soft_clr ? 4'h0 : (ack_reg & ~ack_clr) | ack_set;
      end
   end

   // Soft and selective resets clear different subsets
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         cmd_reg <= 16'h0000;
         gp_reg <= 32'h0000_0000;
         cu_base_reg <= 32'h0000_0000;
         ru_base_reg <= 32'h0000_0000;
         hds_reg <= 32'h0000_0000;
         err_cnt_reg <= 32'h0000_0000;
         cfg_done_reg <= 1'b0;
         setup_ok_reg <= 1'b0;
         eeprom_ctrl_out <= 32'h0000_0000;
         phy_mgmt_ctrl_out <= 32'h0000_0000;
         cu_list_ptr_out <= 32'h0000_0000;
         ru_area_ptr_out <= 32'h0000_0000;
      end else if (soft_clr) begin // see (RULE_11)
         cmd_reg <= 16'h0000;
         gp_reg <= 32'h0000_0000;
         cu_base_reg <= 32'h0000_0000;
         ru_base_reg <= 32'h0000_0000;
         hds_reg <= 32'h0000_0000;
         err_cnt_reg <= 32'h0000_0000;
         cfg_done_reg <= 1'b0;
         setup_ok_reg <= 1'b0;
         eeprom_ctrl_out <= 32'h0000_0000;
         phy_mgmt_ctrl_out <= 32'h0000_0000;
         cu_list_ptr_out <= 32'h0000_0000;
         ru_area_ptr_out <= 32'h0000_0000;
      end else if (sel_clr) begin // see (RULE_12)
         cmd_reg <= 16'h0000;
         gp_reg <= 32'h0000_0000;
         cfg_done_reg <= 1'b0; // see (RULE_09)
         eeprom_ctrl_out <= 32'h0000_0000;
         phy_mgmt_ctrl_out <= 32'h0000_0000;
      end else begin
         if (wr && hit(acc_offset_in, hsm_pkg::OFS_SCB_WORD)) begin
            cmd_reg <= acc_wdata_in[31:16];
         end else if (cmd_ok) begin
            cmd_reg <= 16'h0000;
         end
         if (wr && hit(acc_offset_in, hsm_pkg::OFS_GEN_PTR)) begin
            gp_reg <= acc_wdata_in;
         end
         // Base loads only legal with both engines idle
         if (cmd_ok && both_idle && cu_cmd == hsm_pkg::CU_LOAD_BASE) begin
            cu_base_reg <= gp_reg;
         end
         if (cmd_ok && both_idle && ru_cmd == hsm_pkg::RU_LOAD_BASE) begin
            ru_base_reg <= gp_reg;
         end
         if (cmd_ok && cu_cmd == hsm_pkg::CU_START) begin
            cu_list_ptr_out <= cu_base_reg + gp_reg; // see (RULE_05)
         end
         if (cmd_ok && ru_cmd == hsm_pkg::RU_START) begin
            ru_area_ptr_out <= ru_base_reg + gp_reg; // see (RULE_05)
         end
         if (err_event_in) begin
            err_cnt_reg <= err_cnt_reg + 32'h0000_0001;
         end
         if (action_done_in && action_code_in == hsm_pkg::ACT_CONFIGURE) begin
            cfg_done_reg <= 1'b1; // see (RULE_09)
         end
         if (setup_wr_in) begin
            setup_ok_reg <= 1'b1;
         end
         if (wr && hit(acc_offset_in, hsm_pkg::OFS_EEPROM)) begin
            eeprom_ctrl_out <= acc_wdata_in; // see (RULE_08)
         end
         if (wr && hit(acc_offset_in, hsm_pkg::OFS_PHY_MGMT)) begin
            phy_mgmt_ctrl_out <= acc_wdata_in; // see (RULE_08)
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Full 32 bits: cu state at 7:6, ru state at 3:2
   wire [31:0] scb_word = {cmd_reg, ack_reg, 4'h0, 2'(cu_reg),
      2'b00, 2'(ru_reg), 2'b00}; // see (RULE_04)
   wire [31:0] rd_mux =
      hit(acc_offset_in, hsm_pkg::OFS_SCB_WORD) ? scb_word :
      hit(acc_offset_in, hsm_pkg::OFS_GEN_PTR) ? gp_reg :
      hit(acc_offset_in, hsm_pkg::OFS_EEPROM) ?
         {eeprom_ctrl_out[31:4], ee_sync, eeprom_ctrl_out[2:0]} :
      hit(acc_offset_in, hsm_pkg::OFS_PHY_MGMT) ? phy_mgmt_ctrl_out :
      32'h0000_0000;

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         acc_rdata_out <= 32'h0000_0000;
      end else if (rd) begin
         acc_rdata_out <= rd_mux; // see (RULE_01)
      end
   end

   logic [31:0] mem_rd;
   hsm_setup_mem u_setup (
      .clock_in(clock_in),
      .rst_n_in(rst_n),
      .wr_en_in(setup_wr_in),
      .wr_addr_in(setup_addr_in),
      .wr_data_in(setup_data_in),
      .rd_addr_in(setup_addr_in),
      .rd_data_out(mem_rd)
   );

   // Setup survives selective reset, lost on software reset
   assign setup_rd_data_out = setup_ok_reg ? mem_rd : 32'h0000_0000;
   assign scb_fetch_out = fetch_reg;
   assign rfd_data_addr_out = rfd_addr_in +
      hsm_pkg::RFD_HDR_BYTES; // see (RULE_07)
   assign action_is_tx_out =
      (action_code_in == hsm_pkg::ACT_TRANSMIT); // see (RULE_06)
   assign tx_enable_out =
      cfg_done_reg && cu_reg == hsm_pkg::ENG_ACTIVE; // see (RULE_09)
   assign rx_enable_out = cfg_done_reg && ru_reg == hsm_pkg::ENG_ACTIVE;
   assign irq_out = |ack_reg; // see (RULE_04)
   assign selftest_busy_out = st_reg && busy;

   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n);

   a_fetch_on_write: assert property ( // see (RULE_14)
      wr_scb |=> scb_fetch_out)
      else $error("control block write not fetched");
   a_busy_ignores_cmd: assert property ( // see (RULE_15)
      (busy && fetch_reg) |=> cu_reg == hsm_pkg::ENG_IDLE)
      else $error("command accepted during reset");
   a_start_goes_active: assert property ( // see (RULE_03)
      (cmd_ok && !busy && cu_cmd == hsm_pkg::CU_START) |=>
      cu_reg == hsm_pkg::ENG_ACTIVE)
      else $error("start not obeyed");
   // Software reset wipes status on purpose, so it is exempt
   a_status_irq_raise: assert property ( // see (RULE_04)
      (cu_next != cu_reg && !soft_clr) |=> irq_out)
      else $error("state change without interrupt");
   a_start_pointer: assert property ( // see (RULE_05)
      (cmd_ok && cu_cmd == hsm_pkg::CU_START) |=>
      cu_list_ptr_out == $past(cu_base_reg) + $past(gp_reg))
      else $error("list pointer wrong");
   a_reset_no_tx: assert property ( // see (RULE_09)
      sel_clr |=> !tx_enable_out && !rx_enable_out)
      else $error("traffic enabled after reset");
   a_sel_keeps_base: assert property ( // see (RULE_12)
      sel_clr |=> $stable(cu_base_reg) && $stable(hds_reg) &&
      $stable(err_cnt_reg) && ru_reg == hsm_pkg::ENG_IDLE)
      else $error("selective reset lost setup");
   a_soft_keeps_pci: assert property ( // see (RULE_11)
      (soft_clr && !pci_cfg_wr_in) |=>
      cu_base_reg == 32'h0000_0000 && $stable(pci_cfg_out))
      else $error("software reset wrong");
   a_selftest_seq: assert property ( // see (RULE_13)
      (!busy && wr_port && port_op == hsm_pkg::PORT_SELFTEST) |=>
      sel_clr ##1 rs_reg == hsm_pkg::RS_TEST)
      else $error("self test order wrong");
   c_cu_start: cover property (cmd_ok && cu_cmd == hsm_pkg::CU_START);
   c_selftest_end: cover property (st_reg && soft_clr);
   c_tx_on: cover property (tx_enable_out);
   c_io_access: cover property (acc_valid_in && acc_io_space_in);
endmodule

// >>> hsm_pkg.sv
// Purpose: Shared constants for the host shared-memory control core
// Assumes: 32-bit word access to the control/status region
// Notes: Codes and layouts are defined here; core and bench also hard-code the status word layout
package hsm_pkg;
   // Control/status region word offsets
   localparam logic [4:0] OFS_SCB_WORD = 5'h00;
   localparam logic [4:0] OFS_GEN_PTR = 5'h04;
   localparam logic [4:0] OFS_PORT = 5'h08;
   localparam logic [4:0] OFS_EEPROM = 5'h0C;
   localparam logic [4:0] OFS_PHY_MGMT = 5'h10;
   localparam int SCB_BYTES = 8;
   // System control block word fields
   localparam int ACK_LSB = 12;
   localparam int CU_STATE_LSB = 6;
   localparam int RU_STATE_LSB = 2;
   localparam int RU_CMD_LSB = 16;
   localparam int CU_CMD_LSB = 20;
   localparam int ACK_CX = 0;
   localparam int ACK_FR = 1;
   localparam int ACK_CNA = 2;
   localparam int ACK_RNR = 3;
   // Engine commands
   localparam logic [3:0] CU_START = 4'h1;
   localparam logic [3:0] CU_RESUME = 4'h2;
   localparam logic [3:0] CU_ABORT = 4'h4;
   localparam logic [3:0] CU_LOAD_BASE = 4'h6;
   localparam logic [2:0] RU_START = 3'h1;
   localparam logic [2:0] RU_RESUME = 3'h2;
   localparam logic [2:0] RU_ABORT = 3'h4;
   localparam logic [2:0] RU_LOAD_BASE = 3'h6;
   // Port opcodes
   localparam logic [3:0] PORT_SW_RESET = 4'h0;
   localparam logic [3:0] PORT_SELFTEST = 4'h1;
   localparam logic [3:0] PORT_SEL_RESET = 4'h2;
   // Action command codes; only one is a transmit
   localparam logic [2:0] ACT_TRANSMIT = 3'h4;
   localparam logic [2:0] ACT_CONFIGURE = 3'h2;
   // Simplified model: data follows a fixed-size descriptor
   localparam logic [31:0] RFD_HDR_BYTES = 32'h0000_0010;
   // Self-test run time
   localparam int CLK_NS = 40;
   localparam int SELFTEST_NS = 2000;
   localparam int SELFTEST_CYC = (SELFTEST_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_WORDS = 16;
   typedef enum logic [1:0] {ENG_IDLE, ENG_SUSP, ENG_ACTIVE} hsm_eng_t;
   typedef enum logic [1:0] {RS_NONE, RS_SEL, RS_TEST, RS_SOFT} hsm_rst_t;
endpackage

// >>> hsm_setup_mem.sv
// Purpose: Store for configure, station address and multicast setup
// Assumes: One write and one read port on the core clock
// Notes: Contents survive selective reset; validity is kept outside
`timescale 1ns/1ps
module hsm_setup_mem (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic wr_en_in,
   input wire logic [3:0] wr_addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic [3:0] rd_addr_in,
   output logic [31:0] rd_data_out
);
   logic [31:0] mem [hsm_pkg::SETUP_WORDS];

   // Array has no reset so it maps onto plain RAM
   always_ff @(posedge clock_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 32'h0000_0000;
      end else begin
         rd_data_out <= mem[rd_addr_in];
      end
   end
endmodule

// >>> hsm_host_model.sv
// Purpose: Host software side of the shared control region
// Assumes: One access at a time, word offsets only
// Notes: Released lines show inverted data, never the last value
`timescale 1ns/1ps
module hsm_host_model (
   input wire logic clock_in,
   output logic acc_valid_out,
   output logic acc_write_out,
   output logic acc_io_space_out,
   output logic [4:0] acc_offset_out,
   output logic [31:0] acc_wdata_out,
   input wire logic [31:0] acc_rdata_in,
   input wire logic scb_fetch_in
);
   initial begin
      acc_valid_out = 1'b0;
      acc_write_out = 1'b0;
      acc_io_space_out = 1'b0;
      acc_offset_out = 5'h1F;
      acc_wdata_out = 32'hFFFF_FFFF;
   end
   ////////////////////////////////////////////////////////////////////////
   // Engine codes are written here; list events from the bench also change engines
   task automatic wr(input logic io, input logic [4:0] ofs,
         input logic [31:0] d, output logic fetch);
      @(posedge clock_in);
      #1 acc_valid_out = 1'b1;
      acc_write_out = 1'b1;
      acc_io_space_out = io;
      acc_offset_out = ofs;
      acc_wdata_out = d;
      @(posedge clock_in);
      #1 acc_valid_out = 1'b0;
      acc_wdata_out = ~d;
      acc_offset_out = ~ofs;
      // Fetch pulse stands only in the cycle after the write edge
      fetch = scb_fetch_in;
      // Three edges so the command lands before the next look
      repeat (3) @(posedge clock_in);
      #1;
   endtask
   task automatic rd(input logic io, input logic [4:0] ofs,
         output logic [31:0] d);
      @(posedge clock_in);
      #1 acc_valid_out = 1'b1;
      acc_write_out = 1'b0;
      acc_io_space_out = io;
      acc_offset_out = ofs;
      @(posedge clock_in);
      #1 acc_valid_out = 1'b0;
      acc_offset_out = ~ofs;
      @(posedge clock_in);
      #1 d = acc_rdata_in;
   endtask
endmodule

// >>> host_shared_memory_control_tb.sv
// Purpose: Self-checking bench for the shared-memory control core
// Assumes: Host model drives the access port, bench the engine events
// Notes: Status word compared through a mask of documented fields
`timescale 1ns/1ps
module host_shared_memory_control_tb;
   logic clock_in = 1'b0;
   logic resetn_in = 1'b0;
   logic acc_valid, acc_write, acc_io;
   logic [4:0] acc_ofs;
   logic [31:0] acc_wdata, acc_rdata, pci_cfg_data, rfd_addr, setup_data;
   logic [31:0] pci_cfg, cu_ptr, ru_ptr, rfd_data, eeprom, phy, setup_rd;
   logic [31:0] rdv;
   logic [5:0] ev_vec = 6'h00;
   logic [2:0] action_code = 3'h0;
   logic pci_cfg_wr = 1'b0;
   logic setup_wr = 1'b0;
   logic fetch, act_tx, tx_en, rx_en, irq, busy;
   logic fetch_seen;
   logic ee_pin = 1'b1;
   int fail_count = 0;
   int compares = 0;
   localparam logic [31:0] MASK = 32'h0000_F0CC;
   always #20 clock_in = ~clock_in;
   initial begin
      pci_cfg_data = 32'h0;
      rfd_addr = 32'h0;
      setup_data = 32'h0;
   end
   hsm_host_model host (.clock_in(clock_in), .acc_valid_out(acc_valid),
      .acc_write_out(acc_write), .acc_io_space_out(acc_io),
      .acc_offset_out(acc_ofs), .acc_wdata_out(acc_wdata),
      .acc_rdata_in(acc_rdata), .scb_fetch_in(fetch));
   hsm_core dut (.clock_in(clock_in), .resetn_in(resetn_in),
      .acc_valid_in(acc_valid), .acc_write_in(acc_write),
      .acc_io_space_in(acc_io), .acc_offset_in(acc_ofs),
      .acc_wdata_in(acc_wdata), .acc_rdata_out(acc_rdata),
      .pci_cfg_wr_in(pci_cfg_wr), .pci_cfg_data_in(pci_cfg_data),
      .pci_cfg_out(pci_cfg), .cu_list_end_in(ev_vec[0]),
      .cu_suspend_bit_in(ev_vec[1]), .action_code_in(action_code),
      .action_done_in(ev_vec[2]), .frame_rx_in(ev_vec[3]),
      .ru_no_space_in(ev_vec[4]), .rfd_addr_in(rfd_addr),
      .err_event_in(ev_vec[5]), .setup_wr_in(setup_wr),
      .setup_addr_in(4'h3), .setup_data_in(setup_data),
      .eeprom_data_pin_in(ee_pin), .scb_fetch_out(fetch),
      .cu_list_ptr_out(cu_ptr), .ru_area_ptr_out(ru_ptr),
      .rfd_data_addr_out(rfd_data), .action_is_tx_out(act_tx),
      .tx_enable_out(tx_en), .rx_enable_out(rx_en), .irq_out(irq),
      .eeprom_ctrl_out(eeprom), .phy_mgmt_ctrl_out(phy),
      .setup_rd_data_out(setup_rd), .selftest_busy_out(busy));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic w(input logic [4:0] o, input logic [31:0] d);
      host.wr(1'b0, o, d, fetch_seen);
   endtask
   task automatic ev(input int k);
      @(posedge clock_in);
      #1 ev_vec[k] = 1'b1;
      @(posedge clock_in);
      #1 ev_vec[k] = 1'b0;
      @(posedge clock_in);
      #1;
   endtask
   task automatic cu_cmd(input logic [3:0] c);
      w(hsm_pkg::OFS_SCB_WORD, {8'h00, c, 20'h00000});
   endtask
   task automatic st(input string n, input logic [31:0] e);
      host.rd(1'b0, hsm_pkg::OFS_SCB_WORD, rdv);
      chk(n, e, rdv & MASK);
   endtask
   task automatic hw_reset();
      @(posedge clock_in);
      #1 resetn_in = 1'b0;
      repeat (2) @(posedge clock_in);
      #1 resetn_in = 1'b1;
      repeat (3) @(posedge clock_in);
      #1;
   endtask
   task automatic load_side(input logic [31:0] d);
      @(posedge clock_in);
      #1 setup_wr = 1'b1;
      pci_cfg_wr = 1'b1;
      setup_data = d;
      pci_cfg_data = 32'h1111_2222;
      @(posedge clock_in);
      #1 setup_wr = 1'b0;
      pci_cfg_wr = 1'b0;
      repeat (2) @(posedge clock_in);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_map();
      w(hsm_pkg::OFS_EEPROM, 32'h0000_0005);
      chk("fetch_eeprom", 32'h0, {31'h0, fetch_seen});
      chk("eeprom_ctrl", 32'h5, eeprom);
      host.wr(1'b1, hsm_pkg::OFS_PHY_MGMT, 32'h0000_1234, fetch_seen);
      chk("phy_ctrl", 32'h1234, phy);
      host.rd(1'b1, hsm_pkg::OFS_EEPROM, rdv);
      chk("eeprom_io_rd", 32'hD, rdv);
      host.rd(1'b0, 5'h14, rdv);
      chk("unmapped_rd", 32'h0, rdv);
      w(hsm_pkg::OFS_GEN_PTR, 32'h0000_0100);
      chk("fetch_ptr", 32'h1, {31'h0, fetch_seen});
   endtask
   task automatic t_cu();
      cu_cmd(hsm_pkg::CU_START);
      chk("fetch_cmd", 32'h1, {31'h0, fetch_seen});
      chk("cu_ptr", 32'h100, cu_ptr);
      st("cu_active", 32'h0000_4080);
      chk("irq_set", 32'h1, {31'h0, irq});
      chk("tx_unconf", 32'h0, {31'h0, tx_en});
      w(hsm_pkg::OFS_SCB_WORD, 32'h0000_F000);
      chk("irq_clr", 32'h0, {31'h0, irq});
      ev(1);
      st("cu_susp", 32'h0000_4040);
      w(hsm_pkg::OFS_SCB_WORD, {8'h00, hsm_pkg::CU_RESUME, 20'h0F000});
      st("cu_resume", 32'h0000_4080);
      action_code = hsm_pkg::ACT_CONFIGURE;
      ev(2);
      chk("tx_conf", 32'h1, {31'h0, tx_en});
      chk("not_tx", 32'h0, {31'h0, act_tx});
      action_code = hsm_pkg::ACT_TRANSMIT;
      rfd_addr = 32'h0000_0400;
      #1 chk("is_tx", 32'h1, {31'h0, act_tx});
      chk("rfd_data", 32'h410, rfd_data);
      ev(5);
   endtask
   task automatic t_base();
      w(hsm_pkg::OFS_GEN_PTR, 32'h0000_3000);
      cu_cmd(hsm_pkg::CU_LOAD_BASE);
      ev(0);
      w(hsm_pkg::OFS_GEN_PTR, 32'h0000_0010);
      cu_cmd(hsm_pkg::CU_START);
      chk("base_refused", 32'h10, cu_ptr);
      ev(0);
      w(hsm_pkg::OFS_GEN_PTR, 32'h0000_2000);
      cu_cmd(hsm_pkg::CU_LOAD_BASE);
      w(hsm_pkg::OFS_GEN_PTR, 32'h0000_0010);
      cu_cmd(hsm_pkg::CU_START);
      chk("base_loaded", 32'h2010, cu_ptr);
   endtask
   task automatic t_ru();
      w(hsm_pkg::OFS_GEN_PTR, 32'h0000_0080);
      w(hsm_pkg::OFS_SCB_WORD, {13'h0, hsm_pkg::RU_START, 16'hF000});
      chk("ru_ptr", 32'h80, ru_ptr);
      chk("rx_en", 32'h1, {31'h0, rx_en});
      ev(3);
      ev(4);
      st("ru_susp", 32'h0000_A084);
      w(hsm_pkg::OFS_SCB_WORD, {13'h0, hsm_pkg::RU_RESUME, 16'hF000});
      st("ru_resume", 32'h0000_8088);
   endtask
   task automatic t_resets();
      int i;
      load_side(32'hA5A5_0003);
      w(hsm_pkg::OFS_PORT, {28'h0, hsm_pkg::PORT_SEL_RESET});
      st("sel_idle", 32'h0000_C000);
      chk("sel_tx", 32'h0, {31'h0, tx_en | rx_en});
      chk("sel_setup", 32'hA5A5_0003, setup_rd);
      cu_cmd(hsm_pkg::CU_START);
      chk("sel_base", 32'h2000, cu_ptr);
      w(hsm_pkg::OFS_PORT, {28'h0, hsm_pkg::PORT_SELFTEST});
      chk("busy", 32'h1, {31'h0, busy});
      cu_cmd(hsm_pkg::CU_START);
      for (i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clock_in);
      repeat (2) @(posedge clock_in);
      #1 st("test_idle", 32'h0);
      chk("test_end", 32'h0, {31'h0, busy});
      chk("test_setup", 32'h0, setup_rd);
      chk("test_pci", 32'h1111_2222, pci_cfg);
      chk("test_ptr", 32'h0, cu_ptr);
      load_side(32'h0000_5A5A);
      w(hsm_pkg::OFS_PORT, {28'h0, hsm_pkg::PORT_SW_RESET});
      chk("sw_setup", 32'h0, setup_rd);
      chk("sw_pci", 32'h1111_2222, pci_cfg);
      hw_reset();
      chk("hw_pci", 32'h0, pci_cfg);
      chk("hw_eeprom", 32'h0, eeprom);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      // Whole run is about 225 cycles; generous margin
      #(40 * 20000);
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge clock_in);
      #1 resetn_in = 1'b1;
      repeat (3) @(posedge clock_in);
      #1 chk("rst_out", 32'h0, {29'h0, irq, tx_en, rx_en});
      chk("rst_pci", 32'h0, pci_cfg);
      t_map();
      t_cu();
      t_base();
      t_ru();
      t_resets();
      report_and_stop();
   end
endmodule
